// [design/lcdc_base_clk_div.sv]
`timescale 1ns/1ps
`default_nettype none
module lcdc_base_clk_div
   import lcdc_pkg::*;
#(
   parameter int FAST_DIV = LCDC_FAST_DIV,
   parameter int SLOW_DIV = LCDC_SLOW_DIV
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic run,
   input wire logic slow_sel,
   output logic tick
);
   logic [LCDC_DIV_W-1:0] cnt_ff;
   logic [LCDC_DIV_W-1:0] nxt_cnt;
   logic [LCDC_DIV_W-1:0] last;
   logic tick_ff;

   // Selected base clock sets the period of the tick
   assign last = slow_sel ? LCDC_DIV_W'(SLOW_DIV - 1) : LCDC_DIV_W'(FAST_DIV - 1);
   // Restart on a change of rate is avoided; a wrap catches a shorter period
   assign nxt_cnt = (!run || cnt_ff >= last) ? '0 : cnt_ff + 1'b1;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_ff <= '0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tick_ff <= 1'b0;
      end
      else
      begin
         tick_ff <= run && (cnt_ff >= last);
      end
   end

   assign tick = tick_ff;
endmodule : lcdc_base_clk_div
`default_nettype wire

// [design/lcdc_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Setting the driver enable bit makes the driver active so that waveforms are produced; the code keeps it off while the multiplex code is 00.
// - While the display memory clear bit is set, every display data register is forced to zero; the code only passes the bit out on display_memory_clear.
// - The blink enable bit turns blinking on, with source and rate taken from the clock register.
// - In sleep the driver follows the enable bit when sleep disable is 0, and is off when it is 1.
// - The driver may run in sleep only while the internal reference enable is set.
// - The base clock select bit picks 2048 Hz at 0 and 128 Hz at 1 as the frame timing source.
// - Bias mode 0 gives levels of one, one and two steps; mode 1 gives one, two and three steps.
// - Multiplex code 01 gives two commons, 10 three, 11 four, and 00 is reserved.
// - Voltage source select 0 runs the charge pump, 1 runs the external resistor ladder.
// - The bias level field sets the lowest step as a ratio of 31 plus one when its top bit is set.
module lcdc_config_regs
   import lcdc_pkg::*;
#(
   parameter int FAST_DIV = LCDC_FAST_DIV,
   parameter int SLOW_DIV = LCDC_SLOW_DIV
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic sleep_power_mode,
   input wire logic internal_reference_enable,
   input wire logic [1:0] blink_source_field,
   input wire logic [1:0] blink_rate_field,
   output logic driver_active,
   output logic display_memory_clear,
   output logic blink_active,
   output logic [1:0] blink_source,
   output logic [1:0] blink_rate,
   output logic base_clock_tick,
   output logic base_clock_slow,
   output logic [2:0] common_count,
   output logic shared_common_two_pin_is_common,
   output logic shared_common_three_pin_is_common,
   output logic charge_pump_enable,
   output logic ext_ladder_enable,
   output logic bias_step_plus_ref,
   output logic [4:0] bias_step_ratio,
   output logic [5:0] bias_step_divisor,
   output logic [1:0] level_b_mult,
   output logic [1:0] level_c_mult
);
   logic [7:0] main_cfg_ff;
   logic [7:0] vsrc_cfg_ff;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic on_ff;
   logic clr_ff;
   logic blink_ff;
   logic [1:0] blk_src_ff;
   logic [1:0] blk_rate_ff;
   logic slow_ff;
   logic [2:0] coms_ff;
   logic com2_ff;
   logic com3_ff;
   logic pump_ff;
   logic ladder_ff;
   logic plus_ff;
   logic [4:0] ratio_ff;
   logic [1:0] vb_ff;
   logic [1:0] vc_ff;
   logic nxt_on;
   logic mux_valid;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         main_cfg_ff <= LCDC_MAIN_CONFIG_RST;
      end
      else if (sfr_wr && sfr_addr == LCDC_MAIN_CONFIG_ADDR)
      begin
         main_cfg_ff <= sfr_wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         vsrc_cfg_ff <= LCDC_VOLT_SRC_CONFIG_RST;
      end
      else if (sfr_wr && sfr_addr == LCDC_VOLT_SRC_CONFIG_ADDR)
      begin
         vsrc_cfg_ff <= sfr_wdata & LCDC_VSRC_WRITE_MASK;
      end
   end

   // Read data is registered; other addresses read as zero
   always_comb
   begin
      nxt_rdata = '0;
      case (sfr_addr)
         LCDC_MAIN_CONFIG_ADDR: nxt_rdata = main_cfg_ff;
         LCDC_VOLT_SRC_CONFIG_ADDR: nxt_rdata = vsrc_cfg_ff & LCDC_VSRC_WRITE_MASK;
         default: nxt_rdata = '0;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdata_ff <= '0;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Reserved multiplex code keeps the driver off rather than guess a panel
   assign mux_valid = main_cfg_ff[LCDC_MUX_MSB:LCDC_MUX_LSB] != LCDC_MUX_RESERVED;

   // Sleep needs both the enable path and the reference to keep the glass driven
   assign nxt_on = main_cfg_ff[LCDC_DRIVER_ENABLE_BIT] && mux_valid
      && (!sleep_power_mode
         || (!main_cfg_ff[LCDC_SLEEP_DISABLE_BIT] && internal_reference_enable));

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         on_ff <= 1'b0;
         clr_ff <= 1'b0;
         blink_ff <= 1'b0;
         blk_src_ff <= '0;
         blk_rate_ff <= '0;
      end
      else
      begin
         on_ff <= nxt_on;
         clr_ff <= main_cfg_ff[LCDC_DISPLAY_MEMORY_CLEAR_BIT];
         blink_ff <= nxt_on && main_cfg_ff[LCDC_BLINK_ENABLE_BIT];
         blk_src_ff <= blink_source_field;
         blk_rate_ff <= blink_rate_field;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         slow_ff <= 1'b0;
      end
      else
      begin
         slow_ff <= main_cfg_ff[LCDC_BASE_CLOCK_SELECT];
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         coms_ff <= LCDC_COMMONS_TWO;
         com2_ff <= 1'b0;
         com3_ff <= 1'b0;
      end
      else
      begin
         case (main_cfg_ff[LCDC_MUX_MSB:LCDC_MUX_LSB])
            LCDC_MUX_TWO:
            begin
               coms_ff <= LCDC_COMMONS_TWO;
               com2_ff <= 1'b0;
               com3_ff <= 1'b0;
            end
            LCDC_MUX_THREE:
            begin
               coms_ff <= LCDC_COMMONS_THREE;
               com2_ff <= 1'b1;
               com3_ff <= 1'b0;
            end
            LCDC_MUX_FOUR:
            begin
               coms_ff <= LCDC_COMMONS_FOUR;
               com2_ff <= 1'b1;
               com3_ff <= 1'b1;
            end
            default:
            begin
               coms_ff <= LCDC_COMMONS_NONE;
               com2_ff <= 1'b0;
               com3_ff <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pump_ff <= 1'b1;
         ladder_ff <= 1'b0;
      end
      else
      begin
         pump_ff <= !vsrc_cfg_ff[LCDC_VOLTAGE_SOURCE_SELECT];
         ladder_ff <= vsrc_cfg_ff[LCDC_VOLTAGE_SOURCE_SELECT];
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         plus_ff <= 1'b0;
         ratio_ff <= '0;
         vb_ff <= LCDC_MULT_ONE;
         vc_ff <= LCDC_MULT_TWO;
      end
      else
      begin
         plus_ff <= vsrc_cfg_ff[LCDC_BIAS_LEVEL_MSB];
         ratio_ff <= vsrc_cfg_ff[LCDC_BIAS_LEVEL_MSB-1:LCDC_BIAS_LEVEL_LSB];
         vb_ff <= main_cfg_ff[LCDC_BIAS_MODE_BIT] ? LCDC_MULT_TWO : LCDC_MULT_ONE;
         vc_ff <= main_cfg_ff[LCDC_BIAS_MODE_BIT] ? LCDC_MULT_THREE : LCDC_MULT_TWO;
      end
   end

   // Tick only runs while the driver is on, so a stopped driver saves toggling
   lcdc_base_clk_div #(
      .FAST_DIV(FAST_DIV),
      .SLOW_DIV(SLOW_DIV)
   ) u_div (
      .clk(clk),
      .nrst(nrst),
      .run(on_ff),
      .slow_sel(slow_ff),
      .tick(base_clock_tick)
   );

   assign sfr_rdata = rdata_ff;
   assign driver_active = on_ff;
   assign display_memory_clear = clr_ff;
   assign blink_active = blink_ff;
   assign blink_source = blk_src_ff;
   assign blink_rate = blk_rate_ff;
   assign base_clock_slow = slow_ff;
   assign common_count = coms_ff;
   assign shared_common_two_pin_is_common = com2_ff;
   assign shared_common_three_pin_is_common = com3_ff;
   assign charge_pump_enable = pump_ff;
   assign ext_ladder_enable = ladder_ff;
   assign bias_step_plus_ref = plus_ff;
   assign bias_step_ratio = ratio_ff;
   assign bias_step_divisor = LCDC_BIAS_DIVISOR;
   assign level_b_mult = vb_ff;
   assign level_c_mult = vc_ff;
endmodule : lcdc_config_regs
`default_nettype wire

// [design/lcdc_pkg.sv]
`default_nettype none
package lcdc_pkg;
   // Register addresses on the special function register port
   localparam logic [7:0] LCDC_MAIN_CONFIG_ADDR = 8'h95;
   localparam logic [7:0] LCDC_VOLT_SRC_CONFIG_ADDR = 8'h9C;
   // Reset values
   localparam logic [7:0] LCDC_MAIN_CONFIG_RST = 8'h01;
   localparam logic [7:0] LCDC_VOLT_SRC_CONFIG_RST = 8'h00;
   // Main configuration field positions
   localparam int LCDC_DRIVER_ENABLE_BIT = 7;
   localparam int LCDC_DISPLAY_MEMORY_CLEAR_BIT = 6;
   localparam int LCDC_BLINK_ENABLE_BIT = 5;
   localparam int LCDC_SLEEP_DISABLE_BIT = 4;
   localparam int LCDC_BASE_CLOCK_SELECT = 3;
   localparam int LCDC_BIAS_MODE_BIT = 2;
   localparam int LCDC_MUX_MSB = 1;
   localparam int LCDC_MUX_LSB = 0;
   // Voltage source configuration field positions
   localparam int LCDC_VSRC_RESERVED_BIT = 7;
   localparam int LCDC_VOLTAGE_SOURCE_SELECT = 6;
   localparam int LCDC_BIAS_LEVEL_MSB = 5;
   localparam int LCDC_BIAS_LEVEL_LSB = 0;
   localparam logic [7:0] LCDC_VSRC_WRITE_MASK = 8'h7F;
   // Multiplex level codes
   localparam logic [1:0] LCDC_MUX_RESERVED = 2'h0;
   localparam logic [1:0] LCDC_MUX_TWO = 2'h1;
   localparam logic [1:0] LCDC_MUX_THREE = 2'h2;
   localparam logic [1:0] LCDC_MUX_FOUR = 2'h3;
   // Common line counts
   localparam logic [2:0] LCDC_COMMONS_NONE = 3'h0;
   localparam logic [2:0] LCDC_COMMONS_TWO = 3'h2;
   localparam logic [2:0] LCDC_COMMONS_THREE = 3'h3;
   localparam logic [2:0] LCDC_COMMONS_FOUR = 3'h4;
   // Waveform level multipliers of the lowest step
   localparam logic [1:0] LCDC_MULT_ONE = 2'h1;
   localparam logic [1:0] LCDC_MULT_TWO = 2'h2;
   localparam logic [1:0] LCDC_MULT_THREE = 2'h3;
   // Bias step divisor
   localparam logic [5:0] LCDC_BIAS_DIVISOR = 6'h1F;
   // Timing
   localparam longint LCDC_CLK_HZ = 250000000;
   localparam longint LCDC_BASE_FAST_HZ = 2048;
   localparam longint LCDC_BASE_SLOW_HZ = 128;
   localparam int LCDC_FAST_DIV = int'(LCDC_CLK_HZ / LCDC_BASE_FAST_HZ);
   localparam int LCDC_SLOW_DIV = int'(LCDC_CLK_HZ / LCDC_BASE_SLOW_HZ);
   localparam int LCDC_DIV_W = 24;
endpackage : lcdc_pkg
`default_nettype wire

// [verification/lcdc_config_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module lcdc_config_regs_bench
   import lcdc_pkg::*;
;
   localparam logic [7:0] MA = LCDC_MAIN_CONFIG_ADDR;
   localparam logic [7:0] VA = LCDC_VOLT_SRC_CONFIG_ADDR;
   logic clk, nrst, sfr_wr, sleep_power_mode, internal_reference_enable;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, period_ff;
   logic [1:0] blink_source_field, blink_rate_field, blink_source, blink_rate;
   logic [1:0] level_b_mult, level_c_mult;
   logic driver_active, display_memory_clear, blink_active, base_clock_tick, base_clock_slow;
   logic shared_common_two_pin_is_common, shared_common_three_pin_is_common;
   logic charge_pump_enable, ext_ladder_enable, bias_step_plus_ref;
   logic [2:0] common_count;
   logic [4:0] bias_step_ratio;
   logic [5:0] bias_step_divisor;
   int err_count, check_count;
   // Packed so that one compare covers a whole operating state
   wire logic [7:0] fl = {driver_active, blink_active, display_memory_clear, base_clock_slow,
      shared_common_two_pin_is_common, shared_common_three_pin_is_common, charge_pump_enable,
      ext_ladder_enable};
   wire logic [7:0] mv = {level_b_mult, level_c_mult, 1'b0, common_count};
   wire logic [7:0] bv = {bias_step_plus_ref, bias_step_ratio, 2'h0};
   // Short dividers keep frame periods measurable in a brief run
   lcdc_config_regs #(.FAST_DIV(8), .SLOW_DIV(16)) i_lcdc_config_regs (.*);
   lcdc_panel_model i_lcdc_panel_model (.clk, .nrst, .active(driver_active),
      .tick(base_clock_tick), .period_ff);
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
      @(negedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      @(negedge clk);
      chk(sfr_rdata, e);
   endtask : rd
   task automatic wait_gap(input logic [7:0] e);
      for (int i = 0; i < 200 && period_ff !== e; i++)
         @(negedge clk);
      chk(period_ff, e);
      if (period_ff !== e)
         tally_and_finish();
   endtask : wait_gap
   task automatic s_reset;
      rd(MA, LCDC_MAIN_CONFIG_RST);
      rd(VA, LCDC_VOLT_SRC_CONFIG_RST);
      chk(fl, 8'h02);
      chk(mv, 8'h62);
   endtask : s_reset
   task automatic s_mux;
      logic [7:0] w[4] = '{8'h80, 8'h85, 8'h82, 8'h87};
      logic [7:0] f[4] = '{8'h02, 8'h82, 8'h8A, 8'h8E};
      logic [7:0] m[4] = '{8'h60, 8'hB2, 8'h63, 8'hB4};
      for (int i = 0; i < 4; i++)
      begin
         wr(MA, w[i]);
         chk(fl, f[i]);
         chk(mv, m[i]);
         rd(MA, w[i]);
      end
   endtask : s_mux
   task automatic s_sleep;
      wr(MA, 8'h83);
      sleep_power_mode = 1'b1;
      repeat (2) @(negedge clk);
      chk(fl, 8'h0E);
      internal_reference_enable = 1'b1;
      repeat (2) @(negedge clk);
      chk(fl, 8'h8E);
      wr(MA, 8'h93);
      chk(fl, 8'h0E);
      sleep_power_mode = 1'b0;
      repeat (2) @(negedge clk);
      chk(fl, 8'h8E);
   endtask : s_sleep
   task automatic s_tick;
      wr(MA, 8'h83);
      wait_gap(8'h08);
      wr(MA, 8'h8B);
      wait_gap(8'h10);
      chk(fl, 8'h9E);
   endtask : s_tick
   task automatic s_blink_clear;
      wr(MA, 8'hA3);
      chk(fl, 8'hCE);
      chk({4'h0, blink_source, blink_rate}, 8'h09);
      wr(MA, 8'hC3);
      chk(fl, 8'hAE);
      wr(MA, 8'h83);
      chk(fl, 8'h8E);
   endtask : s_blink_clear
   task automatic s_vsrc;
      wr(VA, 8'hFF);
      rd(VA, 8'h7F);
      chk(fl, 8'h8D);
      chk(bv, 8'hFC);
      chk({2'h0, bias_step_divisor}, 8'h1F);
      wr(VA, 8'h25);
      chk(bv, 8'h94);
      chk(fl, 8'h8E);
      wr(8'h96, 8'h00);
      rd(8'h96, 8'h00);
      rd(MA, 8'h83);
   endtask : s_vsrc
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      nrst = 1'b0;
      sfr_wr = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sleep_power_mode = 1'b0;
      internal_reference_enable = 1'b0;
      blink_source_field = 2'h2;
      blink_rate_field = 2'h1;
      err_count = 0;
      check_count = 0;
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      s_reset();
      s_mux();
      s_sleep();
      s_tick();
      s_blink_clear();
      s_vsrc();
      tally_and_finish();
   end
endmodule : lcdc_config_regs_bench
`default_nettype wire

// [verification/lcdc_config_regs_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module lcdc_config_regs_monitor
   import lcdc_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic sleep_power_mode,
   input wire logic internal_reference_enable,
   input wire logic driver_active,
   input wire logic display_memory_clear,
   input wire logic blink_active,
   input wire logic base_clock_tick,
   input wire logic [2:0] common_count,
   input wire logic charge_pump_enable,
   input wire logic ext_ladder_enable,
   input wire logic [1:0] level_b_mult,
   input wire logic [1:0] level_c_mult
);
   localparam logic [7:0] MA = LCDC_MAIN_CONFIG_ADDR;
   localparam logic [7:0] VA = LCDC_VOLT_SRC_CONFIG_ADDR;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_RD_MAIN: assert property (sfr_wr && sfr_addr == MA ##1 !sfr_wr && sfr_addr == MA
      |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("main read back");
   AST_RSV_ZERO: assert property ($past(sfr_addr) == VA |-> !sfr_rdata[7])
      else $error("reserved bit set");
   AST_UNMAPPED: assert property ($past(sfr_addr) != MA && $past(sfr_addr) != VA
      |-> sfr_rdata == 8'h00) else $error("unmapped read");
   AST_CLEAR: assert property (sfr_wr && sfr_addr == MA
      |-> ##2 display_memory_clear == $past(sfr_wdata[6], 2)) else $error("clear");
   AST_VSRC: assert property (sfr_wr && sfr_addr == VA |-> ##2
      ext_ladder_enable == $past(sfr_wdata[6], 2) && charge_pump_enable != ext_ladder_enable)
      else $error("voltage source");
   AST_MUX: assert property (sfr_wr && sfr_addr == MA |-> ##2 common_count ==
      ($past(sfr_wdata[1:0], 2) == 2'h0 ? 3'h0 : {1'b0, $past(sfr_wdata[1:0], 2)} + 3'h1))
      else $error("commons");
   AST_BIAS: assert property (sfr_wr && sfr_addr == MA |-> ##2
      level_b_mult == ($past(sfr_wdata[2], 2) ? 2'h2 : 2'h1) && level_c_mult == level_b_mult + 2'h1)
      else $error("bias levels");
   AST_SLEEP_REF: assert property ($past(sleep_power_mode) && !$past(internal_reference_enable)
      |-> !driver_active) else $error("sleep without reference");
   AST_TICK: assert property (base_clock_tick |-> driver_active || $past(driver_active))
      else $error("tick while off");
   AST_BLINK: assert property (blink_active |-> driver_active)
      else $error("blink while off");
endmodule : lcdc_config_regs_monitor
bind lcdc_config_regs lcdc_config_regs_monitor i_lcdc_config_regs_monitor (.clk, .nrst,
   .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .sleep_power_mode, .internal_reference_enable,
   .driver_active, .display_memory_clear, .blink_active, .base_clock_tick, .common_count,
   .charge_pump_enable, .ext_ladder_enable, .level_b_mult, .level_c_mult);
`default_nettype wire

// [verification/lcdc_panel_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lcdc_panel_model
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic active,
   input wire logic tick,
   output logic [7:0] period_ff
);
   logic [7:0] cnt_ff;
   // Undriven glass sees no frames, so the count restarts
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_ff <= 8'h00;
         period_ff <= 8'h00;
      end
      else if (!active)
         cnt_ff <= 8'h00;
      else if (tick)
      begin
         period_ff <= cnt_ff + 8'h01;
         cnt_ff <= 8'h00;
      end
      else
         cnt_ff <= cnt_ff + 8'h01;
   end
endmodule : lcdc_panel_model
`default_nettype wire
